// File: rtl/msn_node.sv
// serial node: polled slave, point-to-point and token-passing roles
// assumes a framing layer that delivers whole frames synchronous to MCLK
// How it works
// - an interrupted download loses program ownership after 60 s silence
// - only that timeout or a reset clears program ownership
// - RTS is driven and CTS obeyed in the two handshaking settings
// - DSR and DTR are never used; carrier is ignored unless the carrier variant is built
// - plain full duplex sends and receives with no modem line other than carrier in the carrier variant
// - on the shared line we never start while another node transmits
// - a node is an initiator that takes tokens or a responder that answers
// - an initiator's message on the token network starts only while holding the token
// - each token visit sends at most the hold factor of 1 to 4 messages
// - after its messages the node passes the token to the next node
// - node address is 1 to 31 on the token network, never 255; the bit rate is 9600 or 19200
// - up to 31 nodes are tracked on one segment
// - nodes join and leave the rotation without a restart
// - as polled slave we transmit only after being polled
// - as polled slave frames to address 255 are accepted as broadcasts
`default_nettype none
module msn_node
  import msn_pkg::*;
#(
  parameter logic [32:0] OWN_TMO_CYC = OWN_TMO_DEF,
  parameter logic DCD_MON = 1'b0
)(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_STB,
  input wire msn_frame_t RX_FRAME,
  input wire logic LINE_BUSY,
  input wire logic CTS,
  input wire logic DCD,
  input wire logic TX_READY,
  output logic TX_VALID,
  output msn_frame_t TX_FRAME,
  output logic TX_EN,
  output logic RTS,
  output logic BAUD_19K2,
  output logic RX_HIT,
  output logic PROG_OWNED
);

  // first active initiator above me, wrapping; me when none
  function automatic logic [4:0] next_init(input logic [31:0] map,
                                           input logic [4:0] me);
    logic [4:0] a;
    logic found;
    next_init = me;
    found = 1'b0;
    for (int i = 1; i < 32; i++)
    begin
      a = me + 5'(i);
      if (!found && a != 5'h00 && map[a])
      begin
        next_init = a;
        found = 1'b1;
      end
    end
  endfunction : next_init

  // offsets that answer without error
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_TXDATA) ||
             (a == REG_STATUS) || (a == REG_ACTIVE) || (a == REG_RXCNT);
  endfunction : mapped

  msn_mode_t mode_ff;
  logic hs_ff, init_ff, baud_ff;
  logic [1:0] hold_ff;
  logic [7:0] addr_ff;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff, rd_val;
  logic [15:0] buf_mem [2];
  logic wr_ptr_ff, rd_ptr_ff;
  logic [1:0] buf_cnt_ff;
  logic tx_valid_ff, tx_en_ff, rts_ff, hit_ff, own_ff, grant_ff;
  msn_frame_t tx_ff;
  logic [32:0] own_cnt_ff;
  logic [31:0] map_ff;
  logic [15:0] rxcnt_ff;
  msn_tok_t tok_ff, nxt_tok;
  logic [2:0] sent_ff, nxt_sent;
  logic [4:0] pass_to_ff, nxt_pass_to, nxt_holder;
  logic [11:0] tmo_ff, nxt_tmo;
  logic acc, stall, wr_ev, bad_addr, push;
  logic half, hs_on, cts_ok, can_start, rx_ok, hit, load_msg, load_tok;
  logic drop_pass;
  logic [2:0] lim;

  // bus decode; a write lands at the edge that sees PREADY high
  always_comb
  begin
    acc = PSEL && PENABLE && !pready_ff;
    stall = PWRITE && PADDR == REG_TXDATA && buf_cnt_ff == 2'h2;
    wr_ev = PSEL && PENABLE && PWRITE && pready_ff && !pslverr_ff;
    bad_addr = PWDATA[7:0] == BCAST_ADDR ||
               (mode_ff == MD_TOKEN &&
                (PWDATA[7:0] < NODE_MIN || PWDATA[7:0] > NODE_MAX));
    push = wr_ev && PADDR == REG_TXDATA;
  end

  // read mux, unmapped offsets read zero
  always_comb
  begin
    rd_val = 32'h00000000;
    case (PADDR)
      REG_CTRL: rd_val = 32'({hold_ff, baud_ff, init_ff, hs_ff, mode_ff});
      REG_ADDR: rd_val = {24'h000000, addr_ff};
      REG_STATUS:
      begin
        rd_val[ST_OWN] = own_ff;
        rd_val[ST_TOKEN] = (tok_ff == TK_HOLD) || (tok_ff == TK_PASS);
        rd_val[ST_CNT_LO +: 2] = buf_cnt_ff;
        rd_val[ST_TXV] = tx_valid_ff;
        rd_val[ST_GRANT] = grant_ff;
      end
      REG_ACTIVE: rd_val = map_ff;
      REG_RXCNT: rd_val = {16'h0000, rxcnt_ff};
      default: rd_val = 32'h00000000;
    endcase
  end

  // one wait state; a full buffer holds PREADY low on a data write
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else if (CLK_EN)
    begin
      pready_ff <= acc && !stall;
      pslverr_ff <= acc && !stall && (!mapped(PADDR) ||
                    (PWRITE && PADDR == REG_ADDR && bad_addr));
      prdata_ff <= (acc && !PWRITE) ? rd_val : 32'h00000000;
    end
  end

  // configuration registers
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_ff <= MD_FDX;
      hs_ff <= 1'b0;
      init_ff <= 1'b0;
      baud_ff <= 1'b0;
      hold_ff <= HOLD_RST;
      addr_ff <= ADDR_RST;
    end
    else if (CLK_EN && wr_ev)
    begin
      if (PADDR == REG_CTRL)
      begin
        mode_ff <= msn_mode_t'(PWDATA[CTL_MODE_LO +: 2]);
        hs_ff <= PWDATA[CTL_HS];
        init_ff <= PWDATA[CTL_INIT];
        baud_ff <= PWDATA[CTL_BAUD];
        hold_ff <= PWDATA[CTL_HOLD_LO +: 2];
      end
      if (PADDR == REG_ADDR)
        addr_ff <= PWDATA[7:0];
    end
  end

  // line qualifiers
  always_comb
  begin
    half = mode_ff == MD_SLAVE || mode_ff == MD_TOKEN;
    hs_on = mode_ff == MD_FDX_HS || (mode_ff == MD_SLAVE && hs_ff);
    cts_ok = !hs_on || CTS;
    can_start = !tx_valid_ff && !(half && LINE_BUSY) && cts_ok;
    rx_ok = RX_STB && (DCD || !DCD_MON);
    hit = RX_FRAME.dest == addr_ff ||
          (mode_ff == MD_SLAVE && RX_FRAME.dest == BCAST_ADDR);
    lim = {1'b0, hold_ff} + 3'h1;
    nxt_holder = next_init(map_ff, addr_ff[4:0]);
  end

  // token rotation and transmit permission
  always_comb
  begin
    nxt_tok = tok_ff;
    nxt_sent = sent_ff;
    nxt_pass_to = pass_to_ff;
    nxt_tmo = tmo_ff;
    load_msg = 1'b0;
    load_tok = 1'b0;
    drop_pass = 1'b0;
    if (mode_ff != MD_TOKEN || !init_ff)
    begin
      nxt_tok = TK_IDLE;
      load_msg = buf_cnt_ff != 2'h0 && can_start &&
                 (mode_ff[1] == 1'b0 || grant_ff);
    end
    else
    begin
      case (tok_ff)
        TK_IDLE:
          if (rx_ok && RX_FRAME.kind == K_TOKEN && RX_FRAME.dest == addr_ff)
          begin
            nxt_tok = TK_HOLD;
            nxt_sent = 3'h0;
          end
        TK_HOLD:
          if (sent_ff < lim && buf_cnt_ff != 2'h0)
          begin
            load_msg = can_start;
            if (can_start)
              nxt_sent = sent_ff + 3'h1;
          end
          else if (nxt_holder == addr_ff[4:0])
            nxt_sent = 3'h0; // alone on the line: keep the token
          else
            nxt_tok = TK_PASS;
        TK_PASS:
          if (can_start)
          begin
            load_tok = 1'b1;
            nxt_pass_to = nxt_holder;
            nxt_tmo = PASS_TMO_CYC;
            nxt_tok = TK_WAIT;
          end
        TK_WAIT:
          if (rx_ok && RX_FRAME.src[4:0] == pass_to_ff)
            nxt_tok = TK_IDLE;
          else if (tmo_ff == 12'h000)
          begin
            drop_pass = 1'b1;
            nxt_tok = TK_HOLD;
            nxt_sent = lim;
          end
          else
            nxt_tmo = tmo_ff - 12'h001;
        default: nxt_tok = TK_IDLE;
      endcase
    end
  end

  // token state
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tok_ff <= TK_IDLE;
      sent_ff <= 3'h0;
      pass_to_ff <= 5'h00;
      tmo_ff <= 12'h000;
    end
    else if (CLK_EN)
    begin
      tok_ff <= nxt_tok;
      sent_ff <= nxt_sent;
      pass_to_ff <= nxt_pass_to;
      tmo_ff <= nxt_tmo;
    end
  end

  // active initiators learnt from token traffic; a silent target drops out
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      map_ff <= 32'h00000000;
    else if (CLK_EN)
    begin
      if (drop_pass)
        map_ff[pass_to_ff] <= 1'b0;
      if (rx_ok && mode_ff == MD_TOKEN && RX_FRAME.kind == K_TOKEN &&
          RX_FRAME.src >= NODE_MIN && RX_FRAME.src <= NODE_MAX)
        map_ff[RX_FRAME.src[4:0]] <= 1'b1;
    end
  end

  // poll or request grants a single reply
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      grant_ff <= 1'b0;
    else if (CLK_EN)
    begin
      if (load_msg)
        grant_ff <= 1'b0;
      if (rx_ok && RX_FRAME.dest == addr_ff &&
          ((mode_ff == MD_SLAVE && RX_FRAME.kind == K_POLL) ||
           (mode_ff == MD_TOKEN && !init_ff && RX_FRAME.kind == K_DATA)))
        grant_ff <= 1'b1;
    end
  end

  // two-entry buffer; a stalled line leaves words here, not lost
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end
    else if (CLK_EN)
    begin
      if (push)
        wr_ptr_ff <= !wr_ptr_ff;
      if (load_msg)
        rd_ptr_ff <= !rd_ptr_ff;
      buf_cnt_ff <= buf_cnt_ff + 2'(push) - 2'(load_msg);
    end
  end

  // storage has no reset, only the pointers do
  always_ff @(posedge MCLK)
  begin
    if (CLK_EN && push)
      buf_mem[wr_ptr_ff] <= PWDATA[15:0];
  end

  // output stage holds a frame until the line takes it
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_valid_ff <= 1'b0;
      tx_ff <= '0;
    end
    else if (CLK_EN)
    begin
      if (tx_valid_ff && TX_READY)
        tx_valid_ff <= 1'b0;
      if (load_msg)
      begin
        tx_valid_ff <= 1'b1;
        tx_ff <= {K_DATA, buf_mem[rd_ptr_ff][TXD_DEST_LO +: 8], addr_ff,
                  buf_mem[rd_ptr_ff][7:0]};
      end
      else if (load_tok)
      begin
        tx_valid_ff <= 1'b1;
        tx_ff <= {K_TOKEN, 3'h0, nxt_holder, addr_ff, 8'h00};
      end
    end
  end

  // driver enable and modem lines
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_en_ff <= 1'b0;
      rts_ff <= 1'b0;
    end
    else if (CLK_EN)
    begin
      tx_en_ff <= (load_msg || load_tok) || (tx_valid_ff && !TX_READY);
      rts_ff <= hs_on && (buf_cnt_ff != 2'h0 || tx_valid_ff);
    end
  end

  // accepted frames and counter
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      hit_ff <= 1'b0;
      rxcnt_ff <= 16'h0000;
    end
    else if (CLK_EN)
    begin
      hit_ff <= rx_ok && hit;
      if (rx_ok && hit)
        rxcnt_ff <= rxcnt_ff + 16'h0001;
    end
  end

  // ownership: any traffic restarts the timer, silence releases it
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      own_ff <= 1'b0;
      own_cnt_ff <= 33'h00000000;
    end
    else if (CLK_EN)
    begin
      if (rx_ok && (own_ff || (mode_ff == MD_SLAVE && hit &&
                               RX_FRAME.kind == K_OWN)))
      begin
        own_ff <= 1'b1;
        own_cnt_ff <= OWN_TMO_CYC;
      end
      else if (own_ff)
      begin
        own_cnt_ff <= own_cnt_ff - 33'h00000001;
        if (own_cnt_ff <= 33'h00000001)
          own_ff <= 1'b0;
      end
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign TX_VALID = tx_valid_ff;
  assign TX_FRAME = tx_ff;
  assign TX_EN = tx_en_ff;
  assign RTS = rts_ff;
  assign BAUD_19K2 = baud_ff;
  assign RX_HIT = hit_ff;
  assign PROG_OWNED = own_ff;

  a_own_release: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(own_ff) |-> $past(own_cnt_ff) <= 33'h00000001)
    else $error("ownership dropped before the timeout");
  a_own_keep: assert property (@(posedge MCLK) disable iff (!RST_N)
    own_ff && CLK_EN && own_cnt_ff > 33'h00000001 |=> own_ff)
    else $error("ownership lost without timeout");
  a_rts_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
    CLK_EN && mode_ff == MD_FDX |=> !RTS)
    else $error("rts driven in plain full duplex");
  a_cts_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
    !tx_valid_ff && hs_on && !CTS |=> !TX_VALID)
    else $error("frame started without cts");
  a_line_free: assert property (@(posedge MCLK) disable iff (!RST_N)
    !tx_valid_ff && half && LINE_BUSY |=> !TX_VALID)
    else $error("frame started on a busy line");
  a_token_send: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(TX_VALID) && TX_FRAME.kind == K_DATA && $past(mode_ff) == MD_TOKEN
    && $past(init_ff) |-> $past(tok_ff) == TK_HOLD)
    else $error("message sent without the token");
  a_hold_limit: assert property (@(posedge MCLK) disable iff (!RST_N)
    tok_ff == TK_HOLD |-> sent_ff <= lim)
    else $error("too many messages for one token");
  a_pass_next: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(TX_VALID) && TX_FRAME.kind == K_TOKEN |->
    TX_FRAME.dest == {3'h0, $past(nxt_holder)} && tok_ff == TK_WAIT)
    else $error("token passed to the wrong node");
  a_poll_first: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(TX_VALID) && $past(mode_ff) == MD_SLAVE |-> $past(grant_ff))
    else $error("slave sent without a poll");
  a_bcast_hit: assert property (@(posedge MCLK) disable iff (!RST_N)
    CLK_EN && rx_ok && mode_ff == MD_SLAVE && RX_FRAME.dest == BCAST_ADDR
    |=> RX_HIT)
    else $error("broadcast not accepted");

endmodule : msn_node
`default_nettype wire

// File: rtl/msn_pkg.sv
// constants, field layouts and carrier types of the serial token node
// assumes one 100 MHz clock shared by every file that imports it
`default_nettype none
package msn_pkg;
  // clock rate
  localparam int CLK_MHZ = 100;
  localparam logic [32:0] CLK_HZ = 33'h05F5E100;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_ACTIVE = 8'h10;
  localparam logic [7:0] REG_RXCNT = 8'h14;
  // control field positions
  localparam int CTL_MODE_LO = 0;
  localparam int CTL_HS = 2;
  localparam int CTL_INIT = 3;
  localparam int CTL_BAUD = 4;
  localparam int CTL_HOLD_LO = 5;
  // transmit data and status field positions
  localparam int TXD_DEST_LO = 8;
  localparam int ST_OWN = 0;
  localparam int ST_TOKEN = 1;
  localparam int ST_CNT_LO = 2;
  localparam int ST_TXV = 4;
  localparam int ST_GRANT = 5;
  // values after reset
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [1:0] HOLD_RST = 2'h0;
  // addresses
  localparam logic [7:0] BCAST_ADDR = 8'hFF;
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'h1F;
  // timeouts: token pass acknowledge and program ownership
  localparam int PASS_TMO_US = 20;
  localparam logic [11:0] PASS_TMO_CYC = 12'(PASS_TMO_US * CLK_MHZ);
  localparam logic [32:0] OWN_TMO_S = 33'h0000003C;
  localparam logic [32:0] OWN_TMO_DEF = 33'(OWN_TMO_S * CLK_HZ);
  typedef enum logic [1:0] {
    MD_FDX = 2'h0,
    MD_FDX_HS = 2'h1,
    MD_SLAVE = 2'h2,
    MD_TOKEN = 2'h3
  } msn_mode_t;
  typedef enum logic [1:0] {
    K_DATA = 2'h0,
    K_POLL = 2'h1,
    K_TOKEN = 2'h2,
    K_OWN = 2'h3
  } msn_kind_t;
  typedef enum logic [3:0] {
    TK_IDLE = 4'h1,
    TK_HOLD = 4'h2,
    TK_PASS = 4'h4,
    TK_WAIT = 4'h8
  } msn_tok_t;
  typedef struct packed {
    msn_kind_t kind;
    logic [7:0] dest;
    logic [7:0] src;
    logic [7:0] data;
  } msn_frame_t;
endpackage : msn_pkg
`default_nettype wire

// File: rtl/msn_node_unused_guard.sv
`default_nettype none
`default_nettype wire

// File: bench/msn_far.sv
// far-side line layer model: takes frames from the node's output stage
// assumes the node holds TX_VALID and TX_FRAME steady until the take edge
`default_nettype none
module msn_far
  import msn_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic slow,
  input wire logic TX_VALID,
  input wire msn_frame_t TX_FRAME,
  output logic TX_READY,
  output msn_frame_t last_ff,
  output logic [7:0] n_take_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // slow mode stalls every other cycle, as a busy driver would
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      TX_READY <= 1'b0;
    else
      TX_READY <= slow ? ~TX_READY : 1'b1;
  // log each frame at its take edge only
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
    begin
      last_ff <= '0;
      n_take_ff <= 8'h00;
    end
    else if (TX_VALID && TX_READY)
    begin
      last_ff <= TX_FRAME;
      n_take_ff <= n_take_ff + 8'h01;
    end
endmodule : msn_far
`default_nettype wire

// File: bench/tb.sv
// self-checking bench of the serial token node: apb master, frame source
// assumes msn_node with a short ownership timeout and one 100 MHz clock
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import msn_pkg::*;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic rerr, rx_stb, line_busy, cts, dcd, slow, tx_ready, tx_valid;
  logic tx_en, rts, baud_19k2, rx_hit, prog_owned;
  msn_frame_t rx_frame, tx_frame, far_last;
  logic [7:0] far_n, seen;
  int n_fail, n_tests, cyc, hits;

  // 200 cycles stands in for the long ownership timeout
  msn_node #(.OWN_TMO_CYC(33'h0C8)) dut (.MCLK(mclk), .RST_N(rst_n),
    .CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_STB(rx_stb), .RX_FRAME(rx_frame),
    .LINE_BUSY(line_busy), .CTS(cts), .DCD(dcd), .TX_READY(tx_ready),
    .TX_VALID(tx_valid), .TX_FRAME(tx_frame), .TX_EN(tx_en), .RTS(rts),
    .BAUD_19K2(baud_19k2), .RX_HIT(rx_hit), .PROG_OWNED(prog_owned));
  msn_far far (.MCLK(mclk), .RST_N(rst_n), .slow(slow),
    .TX_VALID(tx_valid), .TX_FRAME(tx_frame), .TX_READY(tx_ready),
    .last_ff(far_last), .n_take_ff(far_n));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk)
  begin
    if (rx_hit === 1'b1)
      hits++;
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("tests %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; released only after the edge that sees pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // pready is read at the edge, before the slave's own update lands
    while (pready !== 1'b1)
      @(posedge mclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask : rd

  // one frame pulse; the bus then shows garbage, not the old frame
  task rx(input msn_kind_t k, input logic [7:0] ds, input logic [7:0] sr);
    @(posedge mclk);
    rx_stb <= 1'b1;
    rx_frame <= '{k, ds, sr, 8'h5A};
    @(posedge mclk);
    rx_stb <= 1'b0;
    rx_frame <= ~rx_frame;
  endtask : rx

  // wait for the next frame taken by the far side and compare it
  task take(input msn_frame_t e);
    int i;
    i = 0;
    while (far_n == seen && i < 3000)
    begin
      @(negedge mclk);
      i++;
    end
    seen = seen + 8'h01;
    chk("tx_frame", 32'(e), 32'(far_last));
  endtask : take

  // nothing may leave for n cycles
  task quiet(input int n);
    repeat (n) @(negedge mclk);
    chk("taken", 32'(seen), 32'(far_n));
  endtask : quiet

  task s_regs;
    rd("ctrl", REG_CTRL, 32'h0);
    rd("addr", REG_ADDR, 32'(ADDR_RST));
    wr(8'h18, 32'h1);
    chk("unmapped", 32'h1, 32'(rerr));
    wr(REG_ADDR, 32'hFF);
    chk("addr_255", 32'h1, 32'(rerr));
    rd("addr", REG_ADDR, 32'(ADDR_RST));
  endtask : s_regs

  task s_slave;
    int h;
    wr(REG_CTRL, 32'h2);
    wr(REG_ADDR, 32'h3);
    wr(REG_TXDATA, 32'h07A5);
    quiet(20);
    h = hits;
    rx(K_POLL, 8'h03, 8'h00);
    take('{K_DATA, 8'h07, 8'h03, 8'hA5});
    rx(K_DATA, BCAST_ADDR, 8'h00);
    rx(K_DATA, 8'h09, 8'h00);
    repeat (3) @(negedge mclk);
    chk("rx_hits", 32'(h + 2), 32'(hits));
  endtask : s_slave

  task s_own;
    rx(K_OWN, 8'h03, 8'h00);
    repeat (5) @(negedge mclk);
    chk("owned", 32'h1, 32'(prog_owned));
    wr(REG_CTRL, 32'h6);
    repeat (170) @(negedge mclk);
    chk("owned", 32'h1, 32'(prog_owned));
    repeat (40) @(negedge mclk);
    chk("owned", 32'h0, 32'(prog_owned));
  endtask : s_own

  task s_hs;
    wr(REG_CTRL, 32'h0);
    wr(REG_TXDATA, 32'h0211);
    take('{K_DATA, 8'h02, 8'h03, 8'h11});
    chk("rts", 32'h0, 32'(rts));
    wr(REG_CTRL, 32'h1);
    wr(REG_TXDATA, 32'h0222);
    quiet(10);
    chk("rts", 32'h1, 32'(rts));
    @(posedge mclk);
    cts <= 1'b1;
    take('{K_DATA, 8'h02, 8'h03, 8'h22});
  endtask : s_hs

  task s_token;
    wr(REG_CTRL, 32'h0B);
    wr(REG_TXDATA, 32'h0931);
    wr(REG_TXDATA, 32'h0932);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("fill", 32'h2, 32'(rdata[3:2]));
    quiet(20);
    @(posedge mclk);
    line_busy <= 1'b1;
    rx(K_TOKEN, 8'h03, 8'h05);
    quiet(20);
    @(posedge mclk);
    line_busy <= 1'b0;
    take('{K_DATA, 8'h09, 8'h03, 8'h31});
    take('{K_TOKEN, 8'h05, 8'h03, 8'h00});
    rx(K_DATA, 8'h00, 8'h05);
    quiet(30);
    rd("active", REG_ACTIVE, 32'h20);
    // second visit: hold factor 2 with a stalling far side
    wr(REG_CTRL, 32'h2B);
    wr(REG_TXDATA, 32'h0933);
    @(posedge mclk);
    slow <= 1'b1;
    rx(K_TOKEN, 8'h03, 8'h05);
    take('{K_DATA, 8'h09, 8'h03, 8'h32});
    take('{K_DATA, 8'h09, 8'h03, 8'h33});
    take('{K_TOKEN, 8'h05, 8'h03, 8'h00});
    rx(K_DATA, 8'h00, 8'h05);
    // top address, faster rate: pass wraps to the lowest initiator
    wr(REG_ADDR, 32'h20);
    chk("addr_32", 32'h1, 32'(rerr));
    wr(REG_ADDR, 32'(NODE_MAX));
    wr(REG_CTRL, 32'h1B);
    @(negedge mclk);
    chk("baud", 32'h1, 32'(baud_19k2));
    rx(K_TOKEN, NODE_MAX, 8'h01);
    take('{K_TOKEN, 8'h01, NODE_MAX, 8'h00});
    // node 1 stays silent: it drops out and the pass goes on to node 5
    take('{K_TOKEN, 8'h05, NODE_MAX, 8'h00});
    rd("active", REG_ACTIVE, 32'h20);
    rx(K_DATA, 8'h00, 8'h05);
    // responder: a reply leaves only after a data frame addressed to us
    wr(REG_CTRL, 32'h03);
    wr(REG_TXDATA, 32'h0944);
    quiet(20);
    rx(K_DATA, NODE_MAX, 8'h05);
    take('{K_DATA, 8'h09, NODE_MAX, 8'h44});
  endtask : s_token

  initial
  begin
    {psel, penable, pwrite, rx_stb, line_busy, cts, dcd, slow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_frame = '0;
    seen = 8'h00;
    rst_n = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    s_regs();
    s_slave();
    s_own();
    s_hs();
    s_token();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
